/* File: core/fisc_top.v */
// Flash command logic: identification, boost mode, XIP exit, suspend and security registers
`timescale 1ns/1ps
`include "fisc_consts.vh"
module fisc_top #(
	parameter [7:0]   MFR_ID   = 8'h5a,  // Arbitrary value
	parameter [7:0]   DEV_ID   = 8'h13,  // Arbitrary value
	parameter [7:0]   MEM_TYPE = 8'h40,  // Arbitrary value
	parameter [7:0]   CAPACITY = 8'h14,  // Arbitrary value
	parameter [127:0] UID      = 128'h0123456789abcdef_fedcba9876543210, // Arbitrary
	parameter [23:0]  SE_CYC   = `FISC_SE_CYC,
	parameter [23:0]  PP_CYC   = `FISC_PP_CYC
) (
	input  wire       i_core_clk,
	input  wire       i_rst_n,
	input  wire       i_ce,
	input  wire       i_sck,
	input  wire       i_cs_n,
	input  wire       i_si,
	input  wire       i_array_busy,
	input  wire       i_array_pausable,
	input  wire       i_array_is_prog,
	input  wire       i_deep_pd,
	input  wire       i_write_enable_latch,
	input  wire       i_otp_lock_bit,
	input  wire       i_xip_mode_valid,
	input  wire [7:0] i_xip_mode_byte,
	input  wire [9:0] i_sr_rd_addr,
	output reg        o_so,
	output reg        o_so_oe,
	output reg        o_boost_status_flag,
	output reg        o_paused_flag,
	output reg        o_busy_flag,
	output reg        o_xip_armed,
	output reg        o_pause_req,
	output reg        o_resume_req,
	output reg        o_wel_clr,
	output reg        o_cmd_reject,
	output wire [7:0] o_sr_rd_data
);
	localparam [23:0] RESUME_CYC = `FISC_RESUME_CYC;

	wire [2:0] pins_s;        // Synchronised sck, cs_n, si
	wire       sck_s  = pins_s[2];
	wire       cs_s   = pins_s[1];
	wire       si_s   = pins_s[0];
	reg        sck_d_q;       // Previous sck sample
	reg        cs_d_q;        // Previous cs_n sample
	reg  [2:0] bitcnt_q;      // Bit within received byte
	reg  [7:0] rxsh_q;        // Receive shifter
	reg  [8:0] nbytes_q;      // Bytes received, saturating
	reg  [7:0] act_q;         // Accepted opcode or none
	reg [23:0] addr_q;        // Received address
	reg  [2:0] obit_q;        // Bit within transmitted byte
	reg  [3:0] oidx_q;        // Transmitted byte index
	reg  [7:0] txsh_q;        // Transmit shifter
	reg        pause_prog_q;  // Paused operation was a program
	reg        sr_busy_q;     // Security register cycle running
	reg [23:0] sr_cnt_q;      // Cycles left in that cycle
	reg        hold_q;        // Busy held after resume
	reg [23:0] hold_cnt_q;    // Time left for the engine to restart
	reg        buf_clr_q;     // Clear program buffer
	reg        buf_wr_q;      // Write one program buffer byte
	reg  [7:0] buf_idx_q;     // Buffer byte index
	reg  [7:0] buf_data_q;    // Buffer byte data
	reg        start_q;       // Start walker
	reg        erase_q;       // Walker erases
	wire       walking;       // Walker active

	wire sck_rise = ~sck_d_q & sck_s;
	wire [7:0] tx_byte = id_byte(act_q, oidx_q, addr_q[0]); // Byte to shift out next
	wire sck_fall = sck_d_q & ~sck_s;
	wire cs_rise  = ~cs_d_q & cs_s;
	wire busy_now = sr_busy_q | i_array_busy | hold_q;
	wire [7:0] rx_byte = {rxsh_q[6:0], si_s};
	wire byte_done = sck_rise & ~cs_s & (bitcnt_q == 3'h7);
	wire on_bound  = (bitcnt_q == 3'h0);
	wire sr_addr_ok = (addr_q[23:10] == 14'h0000);

	// Opcodes that a program pause or an erase pause must turn away
	function paused_reject;
		input [7:0] op;
		input       prog;
		begin
			case (op)
				`FISC_OP_WR_STATUS, `FISC_OP_SR_ERASE, `FISC_OP_SECT_ERASE,
				`FISC_OP_BLK32_ERS, `FISC_OP_BLK64_ERS, `FISC_OP_CHIP_ERS_A,
				`FISC_OP_CHIP_ERS_B:
					paused_reject = 1'b1;
				`FISC_OP_SR_PROG, `FISC_OP_PAGE_PROG, `FISC_OP_QPAGE_PROG:
					paused_reject = prog;
				default:
					paused_reject = 1'b0;
			endcase
		end
	endfunction

	// Next identification byte for the running read command
	function [7:0] id_byte;
		input [7:0] op;
		input [3:0] idx;
		input       swap;
		reg [127:0] uid_sh;
		begin
			uid_sh = UID << {idx, 3'b000};
			case (op)
				`FISC_OP_MFR_DEV_ID:
					id_byte = (idx[0] ^ swap) ? DEV_ID : MFR_ID;
				`FISC_OP_3B_ID:
					id_byte = (idx == 4'h0) ? MFR_ID :
					          (idx == 4'h1) ? MEM_TYPE :
					          (idx == 4'h2) ? CAPACITY : 8'h00;
				`FISC_OP_UID:
					id_byte = uid_sh[127:120];
				default:
					id_byte = 8'h00;
			endcase
		end
	endfunction

	// Decide at the opcode whether this block takes the command
	function [7:0] accept_op;
		input [7:0] op;
		input       xip;
		input       dpd;
		input       busy;
		input       write_enable_latch;
		input       lock;
		input       paused;
		input       pprog;
		begin
			accept_op = `FISC_OP_NONE;
			if (xip) begin
				accept_op = `FISC_OP_NONE;
			end else if (dpd) begin
				if (op == `FISC_OP_RELEASE && !busy) begin
					accept_op = op;
				end
			end else begin
				case (op)
					`FISC_OP_MFR_DEV_ID, `FISC_OP_3B_ID, `FISC_OP_UID,
					`FISC_OP_BOOST, `FISC_OP_RELEASE, `FISC_OP_DEEP_PD:
						if (!busy) begin
							accept_op = op;
						end
					`FISC_OP_PAUSE, `FISC_OP_RESUME:
						accept_op = op;
					`FISC_OP_SR_ERASE, `FISC_OP_SR_PROG:
						if (!busy && write_enable_latch && !lock && !(paused && paused_reject(op, pprog))) begin
							accept_op = op;
						end
					default:
						accept_op = `FISC_OP_NONE;
				endcase
			end
		end
	endfunction

	// Pin synchroniser; sck idles low, cs_n and si high, so no false edge
	fisc_sync #(
		.W (3)
	) u_sync (
		.i_core_clk (i_core_clk),
		.i_rst_n    (i_rst_n),
		.i_ce       (i_ce),
		.i_async    ({i_sck, i_cs_n, i_si}),
		.i_rst_val  (3'h3),
		.o_sync     (pins_s)
	);

	// Security register storage
	fisc_secmem u_secmem (
		.i_core_clk (i_core_clk),
		.i_rst_n    (i_rst_n),
		.i_ce       (i_ce),
		.i_buf_clr  (buf_clr_q),
		.i_buf_wr   (buf_wr_q),
		.i_buf_idx  (buf_idx_q),
		.i_buf_data (buf_data_q),
		.i_start    (start_q),
		.i_erase    (erase_q),
		.i_reg_sel  (addr_q[9:8]),
		.i_rd_addr  (i_sr_rd_addr),
		.o_rd_data  (o_sr_rd_data),
		.o_walking  (walking)
	);

	// Serial receive, command framing and output shifting
	always @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			sck_d_q    <= 1'b0;
			cs_d_q     <= 1'b1;
			bitcnt_q   <= 3'h0;
			rxsh_q     <= 8'h00;
			nbytes_q   <= 9'h000;
			act_q      <= `FISC_OP_NONE;
			addr_q     <= 24'h000000;
			obit_q     <= 3'h0;
			oidx_q     <= 4'h0;
			txsh_q     <= 8'h00;
			o_so       <= 1'b0;
			o_so_oe    <= 1'b0;
			buf_clr_q  <= 1'b0;
			buf_wr_q   <= 1'b0;
			buf_idx_q  <= 8'h00;
			buf_data_q <= 8'h00;
			o_cmd_reject <= 1'b0;
		end else if (i_ce) begin
			sck_d_q      <= sck_s;
			cs_d_q       <= cs_s;
			buf_clr_q    <= 1'b0;
			buf_wr_q     <= 1'b0;
			o_cmd_reject <= 1'b0;
			if (cs_s) begin
				// Deselected: drop output and framing at once
				bitcnt_q <= 3'h0;
				nbytes_q <= 9'h000;
				obit_q   <= 3'h0;
				oidx_q   <= 4'h0;
				o_so_oe  <= 1'b0;
			end else begin
				if (sck_rise) begin
					rxsh_q   <= rx_byte;
					bitcnt_q <= bitcnt_q + 3'h1;
				end
				if (byte_done) begin
					if (nbytes_q != `FISC_BYTES_SAT) begin
						nbytes_q <= nbytes_q + 9'h001;
					end
					if (nbytes_q == 9'h000) begin
						// Opcode byte
						act_q <= accept_op(rx_byte, o_xip_armed, i_deep_pd, busy_now,
							i_write_enable_latch, i_otp_lock_bit, o_paused_flag,
							pause_prog_q);
						o_cmd_reject <= o_paused_flag & ~o_xip_armed &
							paused_reject(rx_byte, pause_prog_q);
						buf_clr_q <= 1'b1;
					end else if (nbytes_q < `FISC_ADDR_END) begin
						addr_q <= {addr_q[15:0], rx_byte};
					end else if (act_q == `FISC_OP_SR_PROG) begin
						buf_wr_q   <= 1'b1;
						buf_idx_q  <= addr_q[7:0] + nbytes_q[7:0] - 8'h04;
						buf_data_q <= rx_byte;
					end
				end
				if (sck_fall && (((act_q == `FISC_OP_MFR_DEV_ID) &&
					(nbytes_q >= `FISC_ADDR_END)) || ((act_q == `FISC_OP_3B_ID) &&
					(nbytes_q >= `FISC_ID_START)) || ((act_q == `FISC_OP_UID) &&
					(nbytes_q >= `FISC_UID_START)))) begin
					// Output phase, one bit per falling edge, MSB first
					o_so_oe <= 1'b1;
					obit_q  <= obit_q + 3'h1;
					if (obit_q == 3'h0) begin
						o_so   <= tx_byte[7];
						txsh_q <= {tx_byte[6:0], 1'b0};
						oidx_q <= oidx_q + 4'h1;
					end else begin
						o_so   <= txsh_q[7];
						txsh_q <= {txsh_q[6:0], 1'b0};
					end
				end
			end
		end
	end

	// Mode flags, suspend/resume and self-timed security register cycles
	always @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			o_boost_status_flag <= 1'b0;
			o_paused_flag       <= 1'b0;
			o_busy_flag         <= 1'b0;
			o_xip_armed         <= 1'b0;
			o_pause_req         <= 1'b0;
			o_resume_req        <= 1'b0;
			o_wel_clr           <= 1'b0;
			pause_prog_q        <= 1'b0;
			sr_busy_q           <= 1'b0;
			sr_cnt_q            <= 24'h000000;
			hold_q              <= 1'b0;
			hold_cnt_q          <= 24'h000000;
			start_q             <= 1'b0;
			erase_q             <= 1'b0;
		end else if (i_ce) begin
			o_busy_flag  <= busy_now;
			o_pause_req  <= 1'b0;
			o_resume_req <= 1'b0;
			o_wel_clr    <= 1'b0;
			start_q      <= 1'b0;
			// Continuous-read arming from the read engine's mode byte
			if (i_xip_mode_valid) begin
				o_xip_armed <= (i_xip_mode_byte[7:4] == `FISC_XIP_NIBBLE);
			end else if (byte_done && (nbytes_q == 9'h000) && o_xip_armed &&
				(rx_byte == `FISC_OP_XIP_EXIT)) begin
				o_xip_armed <= 1'b0;
			end
			// Security register cycle timer
			if (sr_busy_q) begin
				if (sr_cnt_q == 24'h000000 && !walking) begin
					sr_busy_q <= 1'b0;
				end else if (sr_cnt_q != 24'h000000) begin
					sr_cnt_q <= sr_cnt_q - 24'h000001;
				end
			end
			// Busy kept up after resume until the engine restarts or RESUME_CYC runs out
			if (hold_q) begin
				if (i_array_busy || hold_cnt_q == 24'h000000) begin
					hold_q <= 1'b0;
				end else begin
					hold_cnt_q <= hold_cnt_q - 24'h000001;
				end
			end
			if (cs_rise && on_bound) begin
				case (act_q)
					`FISC_OP_BOOST:
						if (nbytes_q == `FISC_ADDR_END) begin
							o_boost_status_flag <= 1'b1;
						end
					`FISC_OP_RELEASE, `FISC_OP_DEEP_PD:
						if (nbytes_q != 9'h000) begin
							o_boost_status_flag <= 1'b0;
						end
					`FISC_OP_PAUSE:
						if (nbytes_q == 9'h001 && !o_paused_flag && busy_now &&
							i_array_busy && i_array_pausable && !sr_busy_q) begin
							o_paused_flag <= 1'b1;
							o_pause_req   <= 1'b1;
							pause_prog_q  <= i_array_is_prog;
						end
					`FISC_OP_RESUME:
						if (nbytes_q == 9'h001 && o_paused_flag && !busy_now) begin
							o_paused_flag <= 1'b0;
							o_resume_req  <= 1'b1;
							hold_q        <= 1'b1;
							hold_cnt_q    <= RESUME_CYC;
						end
					`FISC_OP_SR_ERASE:
						if (nbytes_q == `FISC_ADDR_END && sr_addr_ok) begin
							sr_busy_q <= 1'b1;
							sr_cnt_q  <= SE_CYC;
							start_q   <= 1'b1;
							erase_q   <= 1'b1;
							o_wel_clr <= 1'b1;
						end
					`FISC_OP_SR_PROG:
						if (nbytes_q > `FISC_ADDR_END && sr_addr_ok) begin
							sr_busy_q <= 1'b1;
							sr_cnt_q  <= PP_CYC;
							start_q   <= 1'b1;
							erase_q   <= 1'b0;
							o_wel_clr <= 1'b1;
						end
					default:
						start_q <= 1'b0;
				endcase
			end
		end
	end
endmodule // fisc_top

/* File: include/fisc_consts.vh */
// Constants for the flash identification, suspend and security register command block
`ifndef FISC_CONSTS_VH
`define FISC_CONSTS_VH

// Opcodes handled or watched by this block; 66h and 99h are defined but unused
`define FISC_OP_NONE       8'h00
`define FISC_OP_MFR_DEV_ID 8'h90
`define FISC_OP_3B_ID      8'h9f
`define FISC_OP_BOOST      8'ha3
`define FISC_OP_RELEASE    8'hab
`define FISC_OP_DEEP_PD    8'hb9
`define FISC_OP_UID        8'h4b
`define FISC_OP_XIP_EXIT   8'hff
`define FISC_OP_PAUSE      8'h75
`define FISC_OP_RESUME     8'h7a
`define FISC_OP_SR_ERASE   8'h44
`define FISC_OP_SR_PROG    8'h42
`define FISC_OP_WR_STATUS  8'h01
`define FISC_OP_SECT_ERASE 8'h20
`define FISC_OP_BLK32_ERS  8'h52
`define FISC_OP_BLK64_ERS  8'hd8
`define FISC_OP_CHIP_ERS_A 8'hc7
`define FISC_OP_CHIP_ERS_B 8'h60
`define FISC_OP_PAGE_PROG  8'h02
`define FISC_OP_QPAGE_PROG 8'h32
`define FISC_OP_RST_ENABLE 8'h66
`define FISC_OP_RESET      8'h99

// Continuous-read mode byte: upper nibble that arms it
`define FISC_XIP_NIBBLE    4'ha

// Byte counts that frame each command (opcode included)
`define FISC_ADDR_END      9'h004
`define FISC_UID_START     9'h005
`define FISC_ID_START      9'h001
`define FISC_BYTES_SAT     9'h1ff

// Erased security register byte
`define FISC_ERASED_BYTE   8'hff

// Timing: clock period and times in their own units
`define FISC_CLK_NS        4
`define FISC_T_RESUME_NS   200
`define FISC_RESUME_CYC    (`FISC_T_RESUME_NS / `FISC_CLK_NS)
`define FISC_T_SE_US       1000
`define FISC_T_PP_US       1000
`define FISC_SE_CYC        (`FISC_T_SE_US * 1000 / `FISC_CLK_NS)
`define FISC_PP_CYC        (`FISC_T_PP_US * 1000 / `FISC_CLK_NS)

`endif

/* File: core/fisc_sync.v */
// Two-stage synchroniser for pins arriving from outside the core clock
`timescale 1ns/1ps
module fisc_sync #(
	parameter W = 3
) (
	input  wire         i_core_clk,
	input  wire         i_rst_n,
	input  wire         i_ce,
	input  wire [W-1:0] i_async,
	input  wire [W-1:0] i_rst_val,
	output reg  [W-1:0] o_sync
);
	reg [W-1:0] meta_q; // First stage, read only by the second

	// Two flops in series; reset value is a constant from the instance
	always @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			meta_q <= i_rst_val;
			o_sync <= i_rst_val;
		end else if (i_ce) begin
			meta_q <= i_async;
			o_sync <= meta_q;
		end
	end
endmodule // fisc_sync

/* File: core/fisc_secmem.v */
// Four 256-byte security registers with a program buffer and erase/program walker
`timescale 1ns/1ps
`include "fisc_consts.vh"
module fisc_secmem (
	input  wire       i_core_clk,
	input  wire       i_rst_n,
	input  wire       i_ce,
	input  wire       i_buf_clr,
	input  wire       i_buf_wr,
	input  wire [7:0] i_buf_idx,
	input  wire [7:0] i_buf_data,
	input  wire       i_start,
	input  wire       i_erase,
	input  wire [1:0] i_reg_sel,
	input  wire [9:0] i_rd_addr,
	output reg  [7:0] o_rd_data,
	output reg        o_walking
);
	reg [7:0]   mem [0:1023];  // Security register contents
	reg [7:0]   pbuf [0:255];  // Program data buffer
	reg [255:0] valid_q;       // Buffer bytes loaded this command
	reg [8:0]   walk_q;        // Walker position, ends after byte ff
	reg         erase_q;       // Walker erases rather than programs
	reg [1:0]   reg_q;         // Register under the walker

	// Walker control and buffer valid bits
	always @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			valid_q   <= 256'h0;
			walk_q    <= 9'h000;
			erase_q   <= 1'b0;
			reg_q     <= 2'h0;
			o_walking <= 1'b0;
		end else if (i_ce) begin
			if (i_buf_clr) begin
				valid_q <= 256'h0;
			end else if (i_buf_wr) begin
				valid_q[i_buf_idx] <= 1'b1;
			end
			if (i_start) begin
				walk_q    <= 9'h000;
				erase_q   <= i_erase;
				reg_q     <= i_reg_sel;
				o_walking <= 1'b1;
			end else if (o_walking) begin
				walk_q <= walk_q + 9'h001;
				if (walk_q[7:0] == 8'hff) begin
					o_walking <= 1'b0;
				end
			end
		end
	end

	// Array and buffer storage; programming only clears bits
	always @(posedge i_core_clk) begin
		if (i_ce) begin
			if (i_buf_wr) begin
				pbuf[i_buf_idx] <= i_buf_data;
			end
			if (o_walking) begin
				if (erase_q) begin
					mem[{reg_q, walk_q[7:0]}] <= `FISC_ERASED_BYTE;
				end else if (valid_q[walk_q[7:0]]) begin
					mem[{reg_q, walk_q[7:0]}] <=
						mem[{reg_q, walk_q[7:0]}] & pbuf[walk_q[7:0]];
				end
			end
			o_rd_data <= mem[i_rd_addr];
		end
	end
endmodule // fisc_secmem

/* File: test/fisc_top_asserts.sv */
// Concurrent checks on the ports of the flash command block
`timescale 1ns/1ps
`include "fisc_consts.vh"
module fisc_top_asserts (
	input wire       i_core_clk,
	input wire       i_rst_n,
	input wire       i_cs_n,
	input wire       i_array_busy,
	input wire       i_array_pausable,
	input wire       i_write_enable_latch,
	input wire       i_otp_lock_bit,
	input wire       i_xip_mode_valid,
	input wire [7:0] i_xip_mode_byte,
	input wire       o_so_oe,
	input wire       o_paused_flag,
	input wire       o_busy_flag,
	input wire       o_xip_armed,
	input wire       o_pause_req,
	input wire       o_resume_req,
	input wire       o_wel_clr,
	input wire       o_cmd_reject
);
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);
	// Deselected long enough for the pin synchroniser
	sequence s_cs_idle; i_cs_n [*8]; endsequence
	// Self-timed cycle seen running
	sequence s_busy_run; o_busy_flag [*8]; endsequence
	property p_pause_src;
		o_pause_req |-> $past(i_array_busy) && $past(i_array_pausable);
	endproperty
	a_pause_src: assert property (p_pause_src) else $error("pause while idle");
	property p_pause_set; o_pause_req |-> ##[0:2] o_paused_flag; endproperty
	a_pause_set: assert property (p_pause_set) else $error("pause flag not set");
	property p_resume_clr; o_resume_req |-> ##[0:2] !o_paused_flag; endproperty
	a_resume_clr: assert property (p_resume_clr) else $error("pause flag kept");
	property p_resume_busy; o_resume_req |-> ##[1:50] o_busy_flag; endproperty
	a_resume_busy: assert property (p_resume_busy) else $error("busy late");
	property p_wel_src; o_wel_clr |-> i_write_enable_latch && !i_otp_lock_bit; endproperty
	a_wel_src: assert property (p_wel_src) else $error("cycle without unlock");
	property p_wel_busy; o_wel_clr |-> ##[0:2] s_busy_run; endproperty
	a_wel_busy: assert property (p_wel_busy) else $error("cycle not busy");
	property p_oe_idle; s_cs_idle |-> !o_so_oe; endproperty
	a_oe_idle: assert property (p_oe_idle) else $error("output after deselect");
	property p_oe_busy; $rose(o_so_oe) |-> !o_busy_flag; endproperty
	a_oe_busy: assert property (p_oe_busy) else $error("output while busy");
	property p_oe_xip; $rose(o_so_oe) |-> !o_xip_armed; endproperty
	a_oe_xip: assert property (p_oe_xip) else $error("output while armed");
	property p_xip_arm;
		i_xip_mode_valid && i_xip_mode_byte[7:4] == `FISC_XIP_NIBBLE |-> ##[1:2] o_xip_armed;
	endproperty
	a_xip_arm: assert property (p_xip_arm) else $error("mode byte not armed");
	property p_rej; o_cmd_reject |-> o_paused_flag; endproperty
	a_rej: assert property (p_rej) else $error("reject while not paused");
endmodule // fisc_top_asserts
bind fisc_top fisc_top_asserts u_chk (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
	.i_cs_n(i_cs_n), .i_array_busy(i_array_busy), .i_array_pausable(i_array_pausable),
	.i_write_enable_latch(i_write_enable_latch), .i_otp_lock_bit(i_otp_lock_bit),
	.i_xip_mode_valid(i_xip_mode_valid), .i_xip_mode_byte(i_xip_mode_byte),
	.o_so_oe(o_so_oe), .o_paused_flag(o_paused_flag), .o_busy_flag(o_busy_flag),
	.o_xip_armed(o_xip_armed), .o_pause_req(o_pause_req), .o_resume_req(o_resume_req),
	.o_wel_clr(o_wel_clr), .o_cmd_reject(o_cmd_reject));

/* File: test/fisc_host.sv */
// Behavioural SPI host that clocks frames into the flash command block
`timescale 1ns/1ps
module fisc_host (
	input  wire i_core_clk,
	input  wire i_so,
	output reg  o_sck,
	output reg  o_cs_n,
	output reg  o_si
);
	reg [255:0] rx_q = 256'h0; // Bits sampled at each rising sck
	initial begin
		o_sck = 1'b0;
		o_cs_n = 1'b1;
		o_si = 1'b0;
	end
	// Half of the 48 ns link clock
	task automatic half;
		repeat (6) @(posedge i_core_clk);
	endtask
	// Frame of n bytes taken from the top of tx, MSB first
	task automatic xfer(input int n, input logic [255:0] tx);
		int i;
		o_cs_n <= 1'b0;
		for (i = 0; i < n * 8; i++) begin
			o_si <= tx[255 - i];
			half();
			o_sck <= 1'b1;
			rx_q <= {rx_q[254:0], i_so};
			half();
			o_sck <= 1'b0;
		end
		half();
		o_cs_n <= 1'b1; // Deselect on a byte boundary
		o_si <= ~o_si; // Released line stops showing the last bit
		repeat (12) @(posedge i_core_clk);
	endtask
endmodule // fisc_host

/* File: test/fisc_top_tb_top.sv */
// Self-checking bench for the flash command block
`timescale 1ns/1ps
module fisc_top_tb_top;
	localparam [7:0]   MFR = 8'h3c; // Identity values are arbitrary
	localparam [7:0]   DEV = 8'h71;
	localparam [7:0]   MTY = 8'h22;
	localparam [7:0]   CAP = 8'h15;
	localparam [127:0] UIDV = 128'h00112233445566778899aabbccddeeff;
	reg i_core_clk = 1'b0, i_rst_n = 1'b0, busy = 1'b0, pausable = 1'b0, is_prog = 1'b0;
	reg dpd = 1'b0, write_enable_latch = 1'b0, lock = 1'b0, xv = 1'b0, tgl = 1'b0;
	reg  [7:0] xb = 8'h00;
	reg  [9:0] sra = 10'h000;
	wire sck, cs_n, si, so, so_oe, boost, paused, bsy, xip, preq, rreq, welc, rej;
	wire [7:0] srd;
	wire so_line = so_oe ? so : tgl; // Undriven line keeps changing
	int mismatches = 0, compares = 0, cyc = 0, rej_n = 0, oe_n = 0, k, i, n0;
	int p_n = 0, r_n = 0; // Pause and resume request pulses seen
	logic [7:0] d [0:3];
	logic [7:0] rl [0:9] = '{8'h01, 8'h44, 8'h42, 8'h20, 8'h52, 8'hd8, 8'hc7, 8'h60,
		8'h02, 8'h32};
	fisc_top #(.MFR_ID(MFR), .DEV_ID(DEV), .MEM_TYPE(MTY), .CAPACITY(CAP), .UID(UIDV),
		.SE_CYC(24'h00012c), .PP_CYC(24'h00012c)) u_dut (.i_core_clk(i_core_clk),
		.i_rst_n(i_rst_n), .i_ce(1'b1), .i_sck(sck), .i_cs_n(cs_n), .i_si(si),
		.i_array_busy(busy), .i_array_pausable(pausable), .i_array_is_prog(is_prog),
		.i_deep_pd(dpd), .i_write_enable_latch(write_enable_latch), .i_otp_lock_bit(lock),
		.i_xip_mode_valid(xv), .i_xip_mode_byte(xb), .i_sr_rd_addr(sra), .o_so(so),
		.o_so_oe(so_oe), .o_boost_status_flag(boost), .o_paused_flag(paused),
		.o_busy_flag(bsy), .o_xip_armed(xip), .o_pause_req(preq), .o_resume_req(rreq),
		.o_wel_clr(welc), .o_cmd_reject(rej), .o_sr_rd_data(srd));
	fisc_host u_host (.i_core_clk(i_core_clk), .i_so(so_line), .o_sck(sck), .o_cs_n(cs_n),
		.o_si(si));
	always #2 i_core_clk = ~i_core_clk;
	// Event counters, unlock latch model and hang guard
	always @(posedge i_core_clk) begin
		tgl <= ~tgl;
		cyc <= cyc + 1;
		if (rej) rej_n <= rej_n + 1;
		if (so_oe) oe_n <= oe_n + 1;
		if (preq) p_n <= p_n + 1;
		if (rreq) r_n <= r_n + 1;
		if (welc) write_enable_latch <= 1'b0;
		if (cyc == 40000) begin
			mismatches++;
			summarize();
		end
	end
	task automatic summarize;
		if (mismatches == 0 && compares > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp);
		chk8({7'h0, got}, {7'h0, exp});
	endtask
	// Security register byte checked three cycles after its address
	task automatic rd_chk(input logic [9:0] a, input logic [7:0] exp);
		sra <= a;
		repeat (3) @(posedge i_core_clk);
		chk8(srd, exp);
	endtask
	task automatic wait_idle;
		int n;
		for (n = 0; n < 1000 && bsy !== 1'b0; n++) @(posedge i_core_clk);
	endtask
	// Opcodes refused during a pause of the given kind
	function automatic logic f_rej(input logic [7:0] op, input logic prog);
		f_rej = prog || !(op == 8'h02 || op == 8'h32 || op == 8'h42);
	endfunction
	initial begin
		void'($urandom(22));
		repeat (20) @(posedge i_core_clk);
		i_rst_n <= 1'b1;
		repeat (4) @(posedge i_core_clk);
		u_host.xfer(2, {8'h9f, 248'h0});
		u_host.xfer(4, {8'h9f, 248'h0});
		chk8(u_host.rx_q[23:16], MFR);
		chk8(u_host.rx_q[15:8], MTY);
		chk8(u_host.rx_q[7:0], CAP);
		for (k = 0; k < 2; k++) begin
			u_host.xfer(6, {8'h90, 23'h0, k[0], 224'h0});
			chk8(u_host.rx_q[15:8], k ? DEV : MFR);
			chk8(u_host.rx_q[7:0], k ? MFR : DEV);
		end
		u_host.xfer(21, {8'h4b, 248'h0});
		for (i = 0; i < 16; i++) chk8(u_host.rx_q[127-8*i -: 8], UIDV[127-8*i -: 8]);
		for (k = 0; k < 2; k++) begin
			u_host.xfer(4, {8'ha3, 248'h0});
			chk1(boost, 1'b1);
			u_host.xfer(1, {k ? 8'hb9 : 8'hab, 248'h0});
			chk1(boost, 1'b0);
		end
		dpd <= 1'b1; // Boost A3h refused while powered down
		u_host.xfer(4, {8'ha3, 248'h0});
		chk1(boost, 1'b0);
		dpd <= 1'b0;
		u_host.xfer(4, {8'ha3, 248'h0}); // Boost before fast dual/quad reads
		chk1(boost, 1'b1);
		xv <= 1'b1;
		xb <= {4'ha, 4'($urandom)};
		@(posedge i_core_clk);
		xv <= 1'b0;
		repeat (3) @(posedge i_core_clk);
		chk1(xip, 1'b1);
		n0 = oe_n;
		u_host.xfer(4, {8'h9f, 248'h0});
		chk8(8'(oe_n - n0), 8'h00);
		u_host.xfer(1, {8'hff, 248'h0});
		chk1(xip, 1'b0);
		busy <= 1'b1;
		n0 = oe_n;
		u_host.xfer(4, {8'h9f, 248'h0});
		chk8(8'(oe_n - n0), 8'h00);
		u_host.xfer(1, {8'h75, 248'h0});
		chk1(paused, 1'b0);
		pausable <= 1'b1;
		for (k = 0; k < 2; k++) begin
			is_prog <= k[0];
			busy <= 1'b1;
			u_host.xfer(1, {8'h75, 248'h0});
			chk1(paused, 1'b1);
			busy <= 1'b0;
			for (i = 0; i < 10; i++) begin
				n0 = rej_n;
				u_host.xfer(4, {rl[i], 248'h0});
				chk8(8'(rej_n - n0), {7'h0, f_rej(rl[i], k[0])});
			end
			u_host.xfer(1, {8'h7a, 248'h0});
			chk1(paused, 1'b0);
			chk1(bsy, 1'b1);
			busy <= 1'b1;
			repeat (4) @(posedge i_core_clk);
			busy <= 1'b0;
			wait_idle();
		end
		chk8(8'(p_n), 8'h02);
		chk8(8'(r_n), 8'h02);
		write_enable_latch <= 1'b1;
		u_host.xfer(4, {8'h44, 24'h000200, 224'h0});
		chk1(bsy, 1'b1);
		chk1(write_enable_latch, 1'b0);
		wait_idle();
		chk1(bsy, 1'b0);
		rd_chk(10'h203, 8'hff);
		for (i = 0; i < 4; i++) d[i] = 8'($urandom);
		write_enable_latch <= 1'b1;
		u_host.xfer(8, {8'h42, 24'h0002fe, d[0], d[1], d[2], d[3], 192'h0});
		chk1(bsy, 1'b1);
		wait_idle();
		for (i = 0; i < 4; i++) rd_chk({2'h2, 8'(8'hfe + i)}, 8'hff & d[i]);
		lock <= 1'b1;
		write_enable_latch <= 1'b1;
		u_host.xfer(4, {8'h44, 24'h000200, 224'h0});
		chk1(bsy, 1'b0);
		chk1(write_enable_latch, 1'b1);
		summarize();
	end
endmodule // fisc_top_tb_top
